// file: tcc_timer.sv
/*
  8-bit timer/counter with two double-buffered compare channels and
  the timer synchronisation control. assumes a single 100 MHz clock
  that also samples the crystal pin input, and an Avalon-MM master.
*/
`timescale 1ns/1ps
module tcc_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // crystal oscillator pin, sampled
  input wire logic crystalPinIn,
  // interrupt service acknowledge, one pulse per serviced source
  input wire logic [2:0] irqServiced,
  // waveform and interrupt outputs
  output logic compareOutA,
  output logic compareOutB,
  output logic [2:0] irqRequest,
  output logic syncPrescalerRstOut
);
  logic [7:0] ctrlA_ff, ctrlB_ff, counterValue_ff, cmpA_ff, cmpB_ff, bufA_ff, bufB_ff;
  logic [2:0] irqMask_ff, irqFlag_ff;
  logic asyncSel_ff, powerReduce_ff, syncMode_ff, asyncPre_ff, syncPre_ff;
  logic [9:0] prescale_ff;
  logic crystalSmp_ff, crystalOld_ff, blockMatch_ff, waitAns_ff;
  logic outA_ff, outB_ff;
  logic [31:0] readdata_ff;
  tcc_pkg::tcc_bus_t busState_ff;
  logic wrStb, tick, isPwm, atTop, atBottom, countUp_ff;
  logic matchA, matchB, forceA, forceB;
  logic [2:0] clkSel;
  tcc_pkg::tcc_wave_t waveMode;
  logic [7:0] topVal, nxt_counter;

  assign waveMode = tcc_pkg::tcc_wave_t'({ctrlB_ff[tcc_pkg::WGM2_POS], ctrlA_ff[1:0]});
  assign clkSel = ctrlB_ff[2:0];
  assign isPwm = (waveMode != tcc_pkg::WM_NORMAL) && (waveMode != tcc_pkg::WM_CTC);
  assign topVal = (waveMode == tcc_pkg::WM_CTC || waveMode == tcc_pkg::WM_PC_OCA ||
                   waveMode == tcc_pkg::WM_FAST_OCA) ? cmpA_ff : tcc_pkg::MAX_VAL;
  assign atTop = (counterValue_ff == topVal);
  assign atBottom = (counterValue_ff == tcc_pkg::BOTTOM_VAL);
  // bus: one wait cycle, answer on the second edge of a request
  assign wrStb = write && (busState_ff == tcc_pkg::BS_ANSWER) && byteenable[0];

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busState_ff <= tcc_pkg::BS_IDLE;
      waitAns_ff <= 1'b1;
    end else if (busState_ff == tcc_pkg::BS_IDLE && (read || write)) begin
      busState_ff <= tcc_pkg::BS_ANSWER;
      waitAns_ff <= 1'b0;
    end else begin
      busState_ff <= tcc_pkg::BS_IDLE;
      waitAns_ff <= 1'b1;
    end
  end
  assign waitrequest = waitAns_ff;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      readdata_ff <= 32'h0000_0000;
    end else if ((read || write) && busState_ff == tcc_pkg::BS_IDLE) begin
      unique case (address)
        tcc_pkg::OFS_CTRL_A: readdata_ff <= {24'h000000, ctrlA_ff};
        tcc_pkg::OFS_CTRL_B: readdata_ff <= {24'h000000, 2'h0, ctrlB_ff[5:0]};
        tcc_pkg::OFS_COUNT: readdata_ff <= {24'h000000, counterValue_ff};
        tcc_pkg::OFS_CMP_A: readdata_ff <= {24'h000000, isPwm ? bufA_ff : cmpA_ff};
        tcc_pkg::OFS_CMP_B: readdata_ff <= {24'h000000, isPwm ? bufB_ff : cmpB_ff};
        tcc_pkg::OFS_IMASK: readdata_ff <= {29'h0, irqMask_ff};
        tcc_pkg::OFS_IFLAG: readdata_ff <= {29'h0, irqFlag_ff};
        tcc_pkg::OFS_ASYNC: readdata_ff <= {31'h0, asyncSel_ff};
        tcc_pkg::OFS_SYNC: readdata_ff <= {24'h000000, syncMode_ff, 5'h00, asyncPre_ff, syncPre_ff};
        tcc_pkg::OFS_POWER: readdata_ff <= {31'h0, powerReduce_ff};
        default: readdata_ff <= tcc_pkg::UNMAPPED_READ;
      endcase
    end
  end
  assign readdata = readdata_ff;

  // control registers; force bits are strobes and never stored
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrlA_ff <= tcc_pkg::RST_BYTE;
      ctrlB_ff <= tcc_pkg::RST_BYTE;
      irqMask_ff <= 3'h0;
      asyncSel_ff <= 1'b0;
      powerReduce_ff <= 1'b0;
    end else if (wrStb) begin
      if (address == tcc_pkg::OFS_CTRL_A) ctrlA_ff <= writedata[7:0];
      if (address == tcc_pkg::OFS_CTRL_B) ctrlB_ff <= {2'h0, writedata[5:0]};
      if (address == tcc_pkg::OFS_IMASK) irqMask_ff <= writedata[2:0];
      if (address == tcc_pkg::OFS_ASYNC) asyncSel_ff <= writedata[0];
      if (address == tcc_pkg::OFS_POWER) powerReduce_ff <= writedata[0];
    end
  end
  assign forceA = wrStb && address == tcc_pkg::OFS_CTRL_B && writedata[tcc_pkg::FOCA_POS];
  assign forceB = wrStb && address == tcc_pkg::OFS_CTRL_B && writedata[tcc_pkg::FOCB_POS];

  // synchronisation control
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      syncMode_ff <= 1'b0;
      asyncPre_ff <= 1'b0;
      syncPre_ff <= 1'b0;
    end else if (wrStb && address == tcc_pkg::OFS_SYNC) begin
      syncMode_ff <= writedata[tcc_pkg::SYNC_MODE_POS];
      // with sync mode clear both bits drop, so all counters restart together
      asyncPre_ff <= writedata[tcc_pkg::SYNC_MODE_POS] &
                     writedata[tcc_pkg::ASYNC_PRE_POS];
      syncPre_ff <= writedata[tcc_pkg::SYNC_MODE_POS] &
                    writedata[tcc_pkg::SYNC_PRE_POS];
    end
  end
  // the shared prescaler sits outside; this pulse or held level resets it
  always_ff @(posedge clock) begin
    if (!rst_b) syncPrescalerRstOut <= 1'b0;
    else syncPrescalerRstOut <= syncPre_ff ||
      (wrStb && address == tcc_pkg::OFS_SYNC && writedata[tcc_pkg::SYNC_PRE_POS]);
  end

  // own prescaler, fed by io clock or sampled crystal edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      crystalSmp_ff <= 1'b0;
      crystalOld_ff <= 1'b0;
    end else begin
      crystalSmp_ff <= crystalPinIn;
      crystalOld_ff <= crystalSmp_ff;
    end
  end
  logic srcTick;
  assign srcTick = asyncSel_ff ? (crystalSmp_ff & ~crystalOld_ff) : 1'b1;
  always_ff @(posedge clock) begin
    if (!rst_b || asyncPre_ff) prescale_ff <= tcc_pkg::PRE_RST;
    else if (srcTick) prescale_ff <= prescale_ff + 10'h001;
  end
  // taps are left fixed: tap choice is not modelled, select 1 = undivided
  always_comb begin
    unique case (clkSel)
      3'h0: tick = 1'b0;
      3'h1: tick = srcTick;
      3'h2: tick = srcTick && prescale_ff[2:0] == 3'h7;
      3'h3: tick = srcTick && prescale_ff[4:0] == 5'h1F;
      3'h4: tick = srcTick && prescale_ff[5:0] == 6'h3F;
      3'h5: tick = srcTick && prescale_ff[6:0] == 7'h7F;
      3'h6: tick = srcTick && prescale_ff[7:0] == 8'hFF;
      3'h7: tick = srcTick && prescale_ff == 10'h3FF;
    endcase
  end
  logic run;
  assign run = tick && !powerReduce_ff && !asyncPre_ff;

  // counter unit
  always_comb begin
    nxt_counter = counterValue_ff;
    unique case (waveMode)
      tcc_pkg::WM_PC_FF, tcc_pkg::WM_PC_OCA:
        nxt_counter = (countUp_ff && !atTop) || atBottom ?
                      counterValue_ff + 8'h01 : counterValue_ff - 8'h01;
      default:
        nxt_counter = (atTop && waveMode != tcc_pkg::WM_NORMAL) ?
                      tcc_pkg::BOTTOM_VAL : counterValue_ff + 8'h01;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      counterValue_ff <= tcc_pkg::RST_BYTE;
      countUp_ff <= 1'b1;
    end else if (wrStb && address == tcc_pkg::OFS_COUNT) begin
      counterValue_ff <= writedata[7:0];
    end else if (run) begin
      counterValue_ff <= nxt_counter;
      if (atTop) countUp_ff <= 1'b0;
      else if (atBottom) countUp_ff <= 1'b1;
    end
  end

  // a counter write blocks matches until the next timer clock has passed
  always_ff @(posedge clock) begin
    if (!rst_b) blockMatch_ff <= 1'b0;
    else if (wrStb && address == tcc_pkg::OFS_COUNT) blockMatch_ff <= 1'b1;
    else if (run) blockMatch_ff <= 1'b0;
  end
  assign matchA = run && !blockMatch_ff && counterValue_ff == cmpA_ff;
  assign matchB = run && !blockMatch_ff && counterValue_ff == cmpB_ff;

  // compare registers and buffers
  logic updTime;
  assign updTime = run && ((waveMode == tcc_pkg::WM_FAST_FF ||
    waveMode == tcc_pkg::WM_FAST_OCA) ? atBottom : atTop);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cmpA_ff <= tcc_pkg::RST_BYTE;
      cmpB_ff <= tcc_pkg::RST_BYTE;
      bufA_ff <= tcc_pkg::RST_BYTE;
      bufB_ff <= tcc_pkg::RST_BYTE;
    end else begin
      if (wrStb && address == tcc_pkg::OFS_CMP_A) bufA_ff <= writedata[7:0];
      if (wrStb && address == tcc_pkg::OFS_CMP_B) bufB_ff <= writedata[7:0];
      if (!isPwm) begin
        if (wrStb && address == tcc_pkg::OFS_CMP_A) cmpA_ff <= writedata[7:0];
        if (wrStb && address == tcc_pkg::OFS_CMP_B) cmpB_ff <= writedata[7:0];
      end else if (updTime) begin
        cmpA_ff <= bufA_ff;
        cmpB_ff <= bufB_ff;
      end
    end
  end

  // flags: a hardware set beats a clear in the same cycle
  logic [2:0] setFlag, clrFlag;
  logic ovfEvent;
  assign ovfEvent = run && (isPwm ? ((waveMode == tcc_pkg::WM_PC_FF ||
    waveMode == tcc_pkg::WM_PC_OCA) ? atBottom : atTop) :
    counterValue_ff == tcc_pkg::MAX_VAL);
  assign setFlag = {matchB, matchA, ovfEvent};
  assign clrFlag = irqServiced |
    ((wrStb && address == tcc_pkg::OFS_IFLAG) ? writedata[2:0] : 3'h0);
  always_ff @(posedge clock) begin
    if (!rst_b) irqFlag_ff <= 3'h0;
    else irqFlag_ff <= setFlag | (irqFlag_ff & ~clrFlag);
  end
  always_ff @(posedge clock) begin
    if (!rst_b) irqRequest <= 3'h0;
    else irqRequest <= irqFlag_ff & irqMask_ff & ~clrFlag;
  end

  // waveform generator; pin unit and direction control are outside
  function automatic logic waveNext(input logic cur, input logic [1:0] com,
                                    input logic match, input logic frc);
    logic r;
    r = cur;
    if (!isPwm) begin
      if (match || frc) begin
        unique case (com)
          2'h0: r = cur;
          2'h1: r = ~cur;
          2'h2: r = 1'b0;
          2'h3: r = 1'b1;
        endcase
      end
    end else if (com[1]) begin
      if (match) r = countUp_ff ? com[0] : ~com[0];
      else if (updTime && atBottom && waveMode[0]) r = ~com[0];
    end
    return r;
  endfunction
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      outA_ff <= 1'b0;
      outB_ff <= 1'b0;
    end else begin
      outA_ff <= waveNext(outA_ff, ctrlA_ff[tcc_pkg::COMA_POS +: 2], matchA, forceA);
      outB_ff <= waveNext(outB_ff, ctrlA_ff[tcc_pkg::COMB_POS +: 2], matchB, forceB);
    end
  end
  assign compareOutA = outA_ff;
  assign compareOutB = outB_ff;
endmodule

// file: tcc_pkg.sv
/*
  package for the 8-bit timer/counter with two compare channels:
  register offsets, field positions, reset values and mode codes.
  assumes an Avalon-MM slave with 32-bit data, one register per word.
*/
// Summary of operation
// - sync mode set keeps both prescaler reset bits as written, halting counters
// - writing sync mode to zero clears both prescaler reset bits together
// - sync prescaler reset bit resets shared prescaler, self-clears unless sync mode
// - counter and both compare registers are 8 bits wide
// - every interrupt request shows as a flag and has its own mask bit
// - timer clock from prescaled I/O clock, or crystal pin when async select set
// - clock select zero stops the counter
// - bottom is 0x00, max 0xFF, top is 0xFF or compare A by mode
// - counter clears, increments or decrements per the three-bit wave mode field
// - software reads and writes the counter at any time
// - a counter write beats any clear or count in the same cycle
// - overflow flag set per wave mode and usable as interrupt source
// - equality of counter and compare sets compare flag at next timer clock
// - a set compare flag with its mask bit raises an interrupt request
// - compare flag clears on service or by writing one to it
// - waveform output built from match, wave mode, output mode, top and bottom
// - compare double buffering on in PWM modes, off in normal and clear-on-compare
// - buffered compare value moves to active register only at top or bottom
// - compare writes reach buffer when buffered, active register otherwise
// - normal mode counts up, wraps 0xFF to zero, overflow set at zero
// - clear-on-compare mode resets counter to zero at compare A match
// - a counter write blocks all compare matches in the next timer clock
// - force strobe in non-PWM modes updates output only, no flag, no clear
package tcc_pkg;
  localparam logic [5:0] OFS_CTRL_A = 6'h00;
  localparam logic [5:0] OFS_CTRL_B = 6'h04;
  localparam logic [5:0] OFS_COUNT = 6'h08;
  localparam logic [5:0] OFS_CMP_A = 6'h0C;
  localparam logic [5:0] OFS_CMP_B = 6'h10;
  localparam logic [5:0] OFS_IMASK = 6'h14;
  localparam logic [5:0] OFS_IFLAG = 6'h18;
  localparam logic [5:0] OFS_ASYNC = 6'h1C;
  localparam logic [5:0] OFS_SYNC = 6'h20;
  localparam logic [5:0] OFS_SERVICE = 6'h24;
  localparam logic [5:0] OFS_POWER = 6'h28;
  // control A: [7:6] out mode A, [5:4] out mode B, [1:0] wave mode bits 1:0
  localparam int COMA_POS = 6;
  localparam int COMB_POS = 4;
  // control B: [7] force A, [6] force B, [3] wave mode bit 2, [2:0] clock select
  localparam int FOCA_POS = 7;
  localparam int FOCB_POS = 6;
  localparam int WGM2_POS = 3;
  // flag and mask: [2] compare B, [1] compare A, [0] overflow
  localparam int FL_OVF = 0;
  localparam int FL_CA = 1;
  localparam int FL_CB = 2;
  localparam int SYNC_MODE_POS = 7;
  localparam int ASYNC_PRE_POS = 1;
  localparam int SYNC_PRE_POS = 0;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] PRE_RST = 10'h000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0, WM_PC_FF = 3'h1, WM_CTC = 3'h2, WM_FAST_FF = 3'h3,
    WM_RSV4 = 3'h4, WM_PC_OCA = 3'h5, WM_RSV6 = 3'h6, WM_FAST_OCA = 3'h7
  } tcc_wave_t;
  typedef enum logic [1:0] {
    BS_IDLE = 2'h0, BS_ANSWER = 2'h1
  } tcc_bus_t;
endpackage

// file: tcc_timer_monitor.sv
/*
  concurrent checks on the timer/counter ports.
  assumes the one 100 MHz clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module tcc_timer_monitor (
  // clock, reset and bus
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pins
  input wire logic crystalPinIn,
  input wire logic [2:0] irqServiced,
  input wire logic compareOutA,
  input wire logic compareOutB,
  input wire logic [2:0] irqRequest,
  input wire logic syncPrescalerRstOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic syncWr;
  logic maskWr;
  assign syncWr = write && !waitrequest && byteenable[0] && address == tcc_pkg::OFS_SYNC;
  assign maskWr = write && !waitrequest && byteenable[0] && address == tcc_pkg::OFS_IMASK;
  chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait");
  chk_bus_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  chk_unmapped_zero: assert property (read && !waitrequest && address > tcc_pkg::OFS_POWER
    |-> readdata == tcc_pkg::UNMAPPED_READ) else $error("unmapped read not zero");
  chk_mask_quiet: assert property (maskWr && writedata[2:0] == 3'h0 |-> ##2 irqRequest == 3'h0)
    else $error("request with all masks clear");
  chk_sync_pulse: assert property (syncWr && !writedata[7] && writedata[0]
    |-> ##[1:2] syncPrescalerRstOut ##1 !syncPrescalerRstOut) else $error("reset not one pulse");
  chk_sync_hold: assert property (syncWr && writedata[7] && writedata[0]
    |-> ##2 syncPrescalerRstOut [*3]) else $error("prescaler reset not held");
  chk_sync_release: assert property (syncWr && writedata[7:0] == 8'h00
    |-> ##2 !syncPrescalerRstOut [*2]) else $error("prescaler reset not released");
  chk_service_drop: assert property (irqServiced[1] |=> !irqRequest[1])
    else $error("request stands after service");
  chk_reset_idle: assert property (disable iff (1'h0) !rst_b
    |=> waitrequest && irqRequest == 3'h0 && !compareOutA && !compareOutB)
    else $error("outputs not idle after reset");
endmodule
bind tcc_timer tcc_timer_monitor tcc_timer_monitor_i (.clock(clock), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .crystalPinIn(crystalPinIn), .irqServiced(irqServiced), .compareOutA(compareOutA),
  .compareOutB(compareOutB), .irqRequest(irqRequest),
  .syncPrescalerRstOut(syncPrescalerRstOut));

// file: tcc_cpu_model.sv
/*
  far side: watch crystal and the cpu servicing interrupt requests.
  assumes irqRequest drops in the cycle after its service pulse.
*/
`timescale 1ns/1ps
module tcc_cpu_model #(parameter int HALF = 4) (
  // clock, reset and service enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic svcEn,
  input wire logic [2:0] irqRequest,
  // crystal and service pulses
  output logic crystalPinIn,
  output logic [2:0] irqServiced,
  output int svcCnt
);
  int phase = 0;
  int svcTotal = 0;
  // a crystal runs free, reset or not; one driver per pin
  always @(posedge clock) begin
    phase <= (phase == 2 * HALF - 1) ? 0 : phase + 1;
  end
  assign crystalPinIn = (phase >= HALF);
  assign svcCnt = svcTotal;
  // lowest pending source first; a quiet cycle after each pulse avoids double service
  always @(posedge clock) begin
    if (!rst_b || !svcEn || irqServiced != 3'h0) irqServiced <= 3'h0;
    else irqServiced <= irqRequest & (~irqRequest + 3'h1);
    if (irqServiced != 3'h0) svcTotal <= svcTotal + 1;
  end
endmodule

// file: timer_counter_compare_8bit_test.sv
/*
  self-checking bench for the timer/counter with a register model.
  assumes one wait cycle per access and the cpu model beside the design.
*/
`timescale 1ns/1ps
module timer_counter_compare_8bit_test;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [5:0] address = 6'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0;
  logic svcEn = 1'h0;
  logic [31:0] readdata, q;
  logic [31:0] seed = 32'h27;
  logic waitrequest, crystalPinIn, compareOutA, compareOutB, syncPrescalerRstOut;
  logic [2:0] irqServiced, irqRequest;
  int error_cnt = 0;
  int samples_checked = 0;
  int svcCnt;
  int mdl[int];
  always #5 clock = !clock;
  tcc_timer tcc_timer_i (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .crystalPinIn(crystalPinIn), .irqServiced(irqServiced),
    .compareOutA(compareOutA), .compareOutB(compareOutB), .irqRequest(irqRequest),
    .syncPrescalerRstOut(syncPrescalerRstOut));
  tcc_cpu_model tcc_cpu_model_i (.clock(clock), .rst_b(rst_b), .svcEn(svcEn),
    .irqRequest(irqRequest), .crystalPinIn(crystalPinIn), .irqServiced(irqServiced),
    .svcCnt(svcCnt));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access; the request stands until waitrequest is sampled low
  task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'h0 && n < 40);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (w) mdl[a] = d;
    if (n >= 40) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    acc(a, 1'h0, 8'h00);
    chk(q, exp);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'h1;
    for (int a = 0; a < 48; a += 4) rd(6'(a), 32'h0);
    acc(tcc_pkg::OFS_POWER, 1'h1, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      acc(tcc_pkg::OFS_COUNT, 1'h1, rnd());
      acc(tcc_pkg::OFS_CMP_A, 1'h1, rnd());
      acc(tcc_pkg::OFS_CMP_B, 1'h1, rnd());
      repeat (5) @(posedge clock);
      rd(tcc_pkg::OFS_COUNT, mdl[tcc_pkg::OFS_COUNT]);
      rd(tcc_pkg::OFS_CMP_A, mdl[tcc_pkg::OFS_CMP_A]);
      rd(tcc_pkg::OFS_CMP_B, mdl[tcc_pkg::OFS_CMP_B]);
    end
    $display("test stopped registers done");
    acc(tcc_pkg::OFS_SYNC, 1'h1, 8'h83);
    rd(tcc_pkg::OFS_SYNC, 32'h83);
    acc(tcc_pkg::OFS_SYNC, 1'h1, 8'h00);
    rd(tcc_pkg::OFS_SYNC, 32'h0);
    acc(tcc_pkg::OFS_SYNC, 1'h1, 8'h01);
    rd(tcc_pkg::OFS_SYNC, 32'h0);
    $display("test sync control done");
    acc(tcc_pkg::OFS_IFLAG, 1'h1, 8'h07);
    acc(tcc_pkg::OFS_IMASK, 1'h1, 8'h01);
    acc(tcc_pkg::OFS_COUNT, 1'h1, 8'hFE);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h01);
    for (int n = 0; n < 600 && irqRequest[0] !== 1'h1; n++) @(posedge clock);
    chk({31'h0, irqRequest[0]}, 32'h1);
    if (irqRequest[0] !== 1'h1) summarize();
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_IFLAG, 1'h0, 8'h00);
    chk(q & 32'h1, 32'h1);
    acc(tcc_pkg::OFS_IFLAG, 1'h1, 8'h01);
    acc(tcc_pkg::OFS_IFLAG, 1'h0, 8'h00);
    chk(q & 32'h1, 32'h0);
    chk({29'h0, irqRequest}, 32'h0);
    $display("test overflow done");
    acc(tcc_pkg::OFS_IFLAG, 1'h1, 8'h07);
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h70);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'hC0);
    repeat (2) @(posedge clock);
    chk({31'h0, compareOutA}, 32'h1);
    chk({31'h0, compareOutB}, 32'h1);
    rd(tcc_pkg::OFS_IFLAG, 32'h0);
    $display("test force done");
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h02);
    acc(tcc_pkg::OFS_CMP_A, 1'h1, 8'h03);
    acc(tcc_pkg::OFS_COUNT, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_IMASK, 1'h1, 8'h02);
    svcEn <= 1'h1;
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h01);
    for (int i = 0; i < 8; i++) begin
      acc(tcc_pkg::OFS_COUNT, 1'h0, 8'h00);
      chk({31'h0, q[7:0] <= 8'h03}, 32'h1);
    end
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h00);
    svcEn <= 1'h0;
    chk({31'h0, svcCnt > 2}, 32'h1);
    acc(tcc_pkg::OFS_IMASK, 1'h1, 8'h00);
    $display("test clear on compare done");
    acc(tcc_pkg::OFS_IFLAG, 1'h1, 8'h07);
    acc(tcc_pkg::OFS_CMP_A, 1'h1, 8'h40);
    acc(tcc_pkg::OFS_COUNT, 1'h1, 8'h40);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h01);
    repeat (4) @(posedge clock);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_IFLAG, 1'h0, 8'h00);
    chk(q & 32'h2, 32'h0);
    $display("test match blocking done");
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_ASYNC, 1'h1, 8'h01);
    acc(tcc_pkg::OFS_COUNT, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h01);
    repeat (40) @(posedge clock);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_COUNT, 1'h0, 8'h00);
    chk({31'h0, q[7:0] > 8'h00 && q[7:0] < 8'h14}, 32'h1);
    $display("test crystal clock done");
    acc(tcc_pkg::OFS_ASYNC, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_CMP_B, 1'h1, 8'h11);
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h03);
    acc(tcc_pkg::OFS_CMP_B, 1'h1, 8'h22);
    rd(tcc_pkg::OFS_CMP_B, 32'h22);
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h00);
    rd(tcc_pkg::OFS_CMP_B, 32'h11);
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h03);
    acc(tcc_pkg::OFS_COUNT, 1'h1, 8'hFD);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h01);
    repeat (8) @(posedge clock);
    acc(tcc_pkg::OFS_CTRL_B, 1'h1, 8'h00);
    acc(tcc_pkg::OFS_CTRL_A, 1'h1, 8'h00);
    rd(tcc_pkg::OFS_CMP_B, 32'h22);
    $display("test double buffer done");
    summarize();
  end
endmodule
